// file: include/tdc_pkg.sv
// Constants, field layouts and carrier types of the topology discovery control block
//==============================================================================
// Contract
// - Enable bit 15 selects discovery mode and suppresses normal frame traffic.
// - Manual mode: bit 10 picks calibration (1) or measurement (0) for a start.
// - Automatic mode ignores the calibration/measurement selector bit.
// - Bit 9 selects manual (1) or automatic (0) discovery operation.
// - Writing 1 to bit 8 launches the function; self-clearing, 0 when waiting.
// - Automatic start runs calibration then measurement as one sequence.
// - Bit 4 at 0 checks the scrambler during measurement; 1 skips it.
// - Bit 0 at 1 makes this node the reference that originates pulses.
// - Measured node echoes received pulses and never sends one unprompted.
// - Status bit 15 reads 1 when the run has finished; resets to 1.
// - Manual calibration leaves no valid result for software.
// - Status bit 2 flags a handshake error after an automatic run.
// - Status bit 1 flags an erroneous last measurement in either mode.
// - Status bit 0 flags calibration that found no solution.
// - Calibration error is flagged in both manual and automatic runs.
// - After completion the result register holds the last pulse count.
// - Measurement duration is set in 40 ns steps by a writable register.
package tdc_pkg;

  //============================================================================
  // Register map
  localparam logic [15:0] TDC_ADDR_CTRL     = 16'h0016;
  localparam logic [15:0] TDC_ADDR_STATUS   = 16'h0017;
  localparam logic [15:0] TDC_ADDR_RESULT   = 16'h0018;
  localparam logic [15:0] TDC_ADDR_PRECISE  = 16'h0019;
  localparam logic [15:0] TDC_ADDR_DURATION = 16'h001A;

  localparam logic [15:0] TDC_CTRL_RESET     = 16'h0000;
  localparam logic [15:0] TDC_STATUS_RESET   = 16'h8000;
  localparam logic [15:0] TDC_RESULT_RESET   = 16'h0000;
  localparam logic [15:0] TDC_PRECISE_VALUE  = 16'h0FA0;
  localparam logic [15:0] TDC_DURATION_RESET = 16'h7530;

  //============================================================================
  // Control fields
  localparam int TDC_BIT_ENABLE  = 15;
  localparam int TDC_BIT_CAL_OR_MEASURE_SELECT    = 10;
  localparam int TDC_BIT_MANUAL_MODE_SELECT    = 9;
  localparam int TDC_BIT_TRIGGER = 8;
  localparam int TDC_BIT_SCR_OFF = 4;
  localparam int TDC_BIT_REF     = 0;

  // Status fields
  localparam int TDC_BIT_DONE    = 15;
  localparam int TDC_BIT_HND_ERR = 2;
  localparam int TDC_BIT_MEA_ERR = 1;
  localparam int TDC_BIT_CAL_ERR = 0;

  //============================================================================
  // Timing
  localparam int TDC_CLK_PERIOD_NS   = 4;
  localparam int TDC_TICK_NS         = 40;
  localparam int TDC_TICK_CYCLES     = TDC_TICK_NS / TDC_CLK_PERIOD_NS;
  localparam int TDC_CAL_WINDOW_NS   = 2000;
  localparam int TDC_CAL_CYCLES      = TDC_CAL_WINDOW_NS / TDC_CLK_PERIOD_NS;
  localparam int TDC_ECHO_TIMEOUT_NS = 4000;
  localparam int TDC_ECHO_CYCLES     = TDC_ECHO_TIMEOUT_NS / TDC_CLK_PERIOD_NS;

  //============================================================================
  // Carriers
  typedef struct packed {
    logic discovery_enable;
    logic cal_or_measure_select;
    logic manual_mode_select;
    logic scrambler_check_off;
    logic reference_role_select;
  } tdc_ctrl_t;

  typedef struct packed {
    logic done;
    logic handshake_error_flag;
    logic measure_error_flag;
    logic calibration_error_flag;
  } tdc_status_t;

  typedef enum logic [1:0] {
    TDC_S_IDLE,
    TDC_S_CAL,
    TDC_S_HAND,
    TDC_S_MEAS
  } tdc_state_t;

endpackage

// file: rtl/tdc_core.sv
// Topology discovery control, status and pulse engine
module tdc_core
  import tdc_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int CNT_W  = 16
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  input  wire logic [ADDR_W-1:0] REG_ADDR_I,
  input  wire logic              REG_WR_I,
  input  wire logic [15:0]       REG_WDATA_I,
  input  wire logic              REG_RD_I,
  output logic [15:0]            REG_RDATA_O,
  input  wire logic              RX_PULSE_I,
  input  wire logic              SCRAMBLER_ERR_I,
  output logic                   TX_PULSE_O,
  output logic                   TX_INHIBIT_O,
  output logic                   BUSY_O
);

  localparam logic [9:0]  TICK_LAST = 10'(TDC_TICK_CYCLES - 1);
  localparam logic [11:0] CAL_LAST  = 12'(TDC_CAL_CYCLES - 1);
  localparam logic [11:0] ECHO_LAST = 12'(TDC_ECHO_CYCLES - 1);

  //============================================================================
  // Register state
  tdc_ctrl_t   ctrl_q;
  tdc_status_t stat_q;
  tdc_state_t  state_q;
  logic [15:0] duration_q;
  logic [CNT_W-1:0] result_q;
  logic [CNT_W-1:0] count_q;
  logic        auto_q;
  logic [9:0]  tick_q;
  logic [15:0] ticks_q;
  logic [11:0] wait_q;
  logic        pending_q;
  logic        tx_q;

  logic wr_ctrl;
  logic start;
  logic abort;
  logic tick;
  logic meas_end;
  logic scr_fail;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] r);
    hit = (a == ADDR_W'(r));
  endfunction

  assign wr_ctrl = REG_WR_I && hit(REG_ADDR_I, TDC_ADDR_CTRL);
  // Start is only taken while enabled and idle; a start during a run is dropped
  assign start   = wr_ctrl && REG_WDATA_I[TDC_BIT_TRIGGER] && REG_WDATA_I[TDC_BIT_ENABLE]
                   && (state_q == TDC_S_IDLE);
  assign abort   = !ctrl_q.discovery_enable && (state_q != TDC_S_IDLE);
  assign tick    = (tick_q == TICK_LAST);
  assign meas_end = (state_q == TDC_S_MEAS) && tick && (ticks_q >= duration_q);
  assign scr_fail = (state_q == TDC_S_MEAS) && !ctrl_q.scrambler_check_off
                    && SCRAMBLER_ERR_I;

  //============================================================================
  // Control register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q.discovery_enable      <= REG_WDATA_I[TDC_BIT_ENABLE];
      ctrl_q.cal_or_measure_select <= REG_WDATA_I[TDC_BIT_CAL_OR_MEASURE_SELECT];
      ctrl_q.manual_mode_select    <= REG_WDATA_I[TDC_BIT_MANUAL_MODE_SELECT];
      ctrl_q.scrambler_check_off   <= REG_WDATA_I[TDC_BIT_SCR_OFF];
      ctrl_q.reference_role_select <= REG_WDATA_I[TDC_BIT_REF];
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      duration_q <= TDC_DURATION_RESET;
    end else if (REG_WR_I && hit(REG_ADDR_I, TDC_ADDR_DURATION)) begin
      duration_q <= REG_WDATA_I;
    end
  end

  //============================================================================
  // 40 ns reference tick, free running only during a measurement
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_q  <= '0;
      ticks_q <= '0;
    end else if (state_q != TDC_S_MEAS) begin
      tick_q  <= '0;
      ticks_q <= '0;
    end else if (tick) begin
      tick_q  <= '0;
      ticks_q <= ticks_q + 16'h0001;
    end else begin
      tick_q <= tick_q + 10'h001;
    end
  end

  //============================================================================
  // Sequencer
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q   <= TDC_S_IDLE;
      auto_q    <= 1'b0;
      wait_q    <= '0;
      pending_q <= 1'b0;
      count_q   <= '0;
      tx_q      <= 1'b0;
    end else begin
      tx_q <= 1'b0;
      case (state_q)
        TDC_S_IDLE: begin
          if (start) begin
            auto_q  <= !REG_WDATA_I[TDC_BIT_MANUAL_MODE_SELECT];
            wait_q  <= '0;
            count_q <= '0;
            pending_q <= 1'b0;
            // Automatic runs always begin with calibration, selector ignored
            if (!REG_WDATA_I[TDC_BIT_MANUAL_MODE_SELECT] || REG_WDATA_I[TDC_BIT_CAL_OR_MEASURE_SELECT]) begin
              state_q <= TDC_S_CAL;
            end else begin
              state_q <= TDC_S_MEAS;
            end
          end
        end
        TDC_S_CAL: begin
          // Traffic on a line that should be quiet means no calibration solution
          if (abort || RX_PULSE_I) begin
            state_q <= TDC_S_IDLE;
          end else if (wait_q == CAL_LAST) begin
            wait_q <= '0;
            state_q <= auto_q ? TDC_S_HAND : TDC_S_IDLE;
            if (auto_q && ctrl_q.reference_role_select) begin
              tx_q <= 1'b1;
            end
          end else begin
            wait_q <= wait_q + 12'h001;
          end
        end
        TDC_S_HAND: begin
          // Reference waits for its echo; measured node waits for the first pulse
          // A pulse on the last cycle still wins, so the run never ends without done
          if (abort) begin
            state_q <= TDC_S_IDLE;
          end else if (RX_PULSE_I) begin
            wait_q  <= '0;
            state_q <= TDC_S_MEAS;
            // The measured node answers the opening pulse as well
            tx_q    <= !ctrl_q.reference_role_select;
          end else if (wait_q == ECHO_LAST) begin
            state_q <= TDC_S_IDLE;
          end else begin
            wait_q <= wait_q + 12'h001;
          end
        end
        TDC_S_MEAS: begin
          if (abort || meas_end || scr_fail) begin
            state_q <= TDC_S_IDLE;
          end else if (ctrl_q.reference_role_select) begin
            if (!pending_q) begin
              tx_q      <= 1'b1;
              pending_q <= 1'b1;
              wait_q    <= '0;
            end else if (RX_PULSE_I) begin
              pending_q <= 1'b0;
              count_q   <= count_q + CNT_W'(1);
            end else if (wait_q == ECHO_LAST) begin
              state_q <= TDC_S_IDLE;
            end else begin
              wait_q <= wait_q + 12'h001;
            end
          end else if (RX_PULSE_I) begin
            // Only a received pulse can cause a transmit on the measured side
            tx_q    <= 1'b1;
            count_q <= count_q + CNT_W'(1);
          end
        end
        default: begin
          state_q <= TDC_S_IDLE;
        end
      endcase
    end
  end

  //============================================================================
  // Status flags: cleared by an accepted start, set as the run concludes
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stat_q <= tdc_status_t'(4'h8);
    end else if (start) begin
      stat_q <= '0;
    end else begin
      case (state_q)
        TDC_S_CAL: begin
          if (abort) begin
            stat_q.done <= 1'b1;
          end else if (RX_PULSE_I) begin
            stat_q.done                   <= 1'b1;
            stat_q.calibration_error_flag <= 1'b1;
          end else if (wait_q == CAL_LAST && !auto_q) begin
            stat_q.done <= 1'b1;
          end
        end
        TDC_S_HAND: begin
          if (abort) begin
            stat_q.done <= 1'b1;
          end else if (wait_q == ECHO_LAST && !RX_PULSE_I) begin
            stat_q.done                 <= 1'b1;
            stat_q.handshake_error_flag <= auto_q;
          end
        end
        TDC_S_MEAS: begin
          if (abort || meas_end) begin
            stat_q.done <= 1'b1;
          end else if (scr_fail || (ctrl_q.reference_role_select && pending_q
                                    && !RX_PULSE_I && wait_q == ECHO_LAST)) begin
            stat_q.done               <= 1'b1;
            stat_q.measure_error_flag <= 1'b1;
          end
        end
        default: begin
          stat_q <= stat_q;
        end
      endcase
    end
  end

  // Result is taken only from measurements, so a manual calibration leaves it stale
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      result_q <= CNT_W'(TDC_RESULT_RESET);
    end else if (state_q == TDC_S_MEAS && state_q != TDC_S_IDLE
                 && (abort || meas_end || scr_fail || wait_q == ECHO_LAST)) begin
      result_q <= count_q;
    end
  end

  //============================================================================
  // Register read, one cycle after the strobe
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= '0;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= '0;
      if (hit(REG_ADDR_I, TDC_ADDR_CTRL)) begin
        REG_RDATA_O[TDC_BIT_ENABLE]  <= ctrl_q.discovery_enable;
        REG_RDATA_O[TDC_BIT_CAL_OR_MEASURE_SELECT]    <= ctrl_q.cal_or_measure_select;
        REG_RDATA_O[TDC_BIT_MANUAL_MODE_SELECT]    <= ctrl_q.manual_mode_select;
        REG_RDATA_O[TDC_BIT_TRIGGER] <= (state_q != TDC_S_IDLE);
        REG_RDATA_O[TDC_BIT_SCR_OFF] <= ctrl_q.scrambler_check_off;
        REG_RDATA_O[TDC_BIT_REF]     <= ctrl_q.reference_role_select;
      end else if (hit(REG_ADDR_I, TDC_ADDR_STATUS)) begin
        REG_RDATA_O[TDC_BIT_DONE]    <= stat_q.done;
        REG_RDATA_O[TDC_BIT_HND_ERR] <= stat_q.handshake_error_flag;
        REG_RDATA_O[TDC_BIT_MEA_ERR] <= stat_q.measure_error_flag;
        REG_RDATA_O[TDC_BIT_CAL_ERR] <= stat_q.calibration_error_flag;
      end else if (hit(REG_ADDR_I, TDC_ADDR_RESULT)) begin
        REG_RDATA_O <= 16'(result_q);
      end else if (hit(REG_ADDR_I, TDC_ADDR_PRECISE)) begin
        REG_RDATA_O <= TDC_PRECISE_VALUE;
      end else if (hit(REG_ADDR_I, TDC_ADDR_DURATION)) begin
        REG_RDATA_O <= duration_q;
      end
    end
  end

  //============================================================================
  // Line side
  assign TX_PULSE_O   = tx_q;
  assign TX_INHIBIT_O = ctrl_q.discovery_enable;
  assign BUSY_O       = (state_q != TDC_S_IDLE);

endmodule

// file: tb/tdc_peer.sv
// Peer node model on the shared discovery line
module tdc_peer #(
  parameter int DLY = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic line_in_i,
  input  wire logic echo_en_i,
  input  wire logic send_i,
  output logic      line_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  //==========================================================================
  // Echo path; the line rests low unless a pulse is echoed or commanded
  logic [DLY-1:0] dly_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dly_q <= '0;
    end else begin
      dly_q <= {dly_q[DLY-2:0], line_in_i & echo_en_i};
    end
  end
  assign line_out_o = dly_q[DLY-1] | send_i;
endmodule

// file: tb/tdc_checker.sv
// Port-level assertions for the topology discovery control block
module tdc_checker
  import tdc_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int CNT_W  = 16
) (
  input wire logic              CLK_I,
  input wire logic              RST_I,
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic              REG_WR_I,
  input wire logic [15:0]       REG_WDATA_I,
  input wire logic              REG_RD_I,
  input wire logic [15:0]       REG_RDATA_O,
  input wire logic              RX_PULSE_I,
  input wire logic              SCRAMBLER_ERR_I,
  input wire logic              TX_PULSE_O,
  input wire logic              TX_INHIBIT_O,
  input wire logic              BUSY_O
);
  timeunit 1ns;
  timeprecision 1ps;
  //==========================================================================
  // Role shadow, needed to judge unprompted pulses
  logic ref_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ref_q <= 1'b0;
    end else if (REG_WR_I && REG_ADDR_I == TDC_ADDR_CTRL) begin
      ref_q <= REG_WDATA_I[TDC_BIT_REF];
    end
  end
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  //==========================================================================
  // Sequences
  sequence start_req;
    REG_WR_I && REG_ADDR_I == TDC_ADDR_CTRL && REG_WDATA_I[15] && REG_WDATA_I[8] && !BUSY_O;
  endsequence
  sequence abort_req;
    REG_WR_I && REG_ADDR_I == TDC_ADDR_CTRL && !REG_WDATA_I[15] && BUSY_O;
  endsequence
  //==========================================================================
  // Assertions
  chk_inhibit_follow: assert property (REG_WR_I && REG_ADDR_I == TDC_ADDR_CTRL |=>
    TX_INHIBIT_O == $past(REG_WDATA_I[15])) else $error("inhibit not following enable");
  chk_start_busy: assert property (start_req |=> BUSY_O)
    else $error("accepted start did not begin a run");
  chk_start_refused: assert property (REG_WR_I && REG_ADDR_I == TDC_ADDR_CTRL
    && !REG_WDATA_I[15] && !BUSY_O |=> !BUSY_O) else $error("run began while disabled");
  chk_abort_idle: assert property (abort_req |-> ##[1:4] !BUSY_O)
    else $error("disable did not end the run");
  chk_echo_only: assert property (!ref_q && TX_PULSE_O |-> $past(RX_PULSE_I))
    else $error("measured node pulsed unprompted");
  chk_done_low_busy: assert property (REG_RD_I && REG_ADDR_I == TDC_ADDR_STATUS
    && BUSY_O |=> !REG_RDATA_O[15]) else $error("done read high during run");
  chk_trigger_idle: assert property (REG_RD_I && REG_ADDR_I == TDC_ADDR_CTRL
    && !BUSY_O |=> !REG_RDATA_O[8]) else $error("start bit read high when idle");
  chk_status_rsvd: assert property (REG_RD_I && REG_ADDR_I == TDC_ADDR_STATUS
    |=> REG_RDATA_O[14:3] == 12'h000) else $error("status reserved bits not zero");
endmodule

bind tdc_core tdc_checker #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_chk (.CLK_I(CLK_I),
  .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .RX_PULSE_I(RX_PULSE_I),
  .SCRAMBLER_ERR_I(SCRAMBLER_ERR_I), .TX_PULSE_O(TX_PULSE_O),
  .TX_INHIBIT_O(TX_INHIBIT_O), .BUSY_O(BUSY_O));

// file: tb/tb.sv
// Self-checking testbench for the topology discovery control block
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module tb
  import tdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr_s, rd_s, rx, scr, tx, inh, busy, echo_en, send;
  logic [15:0] addr, wdata, rdata, st, res;
  int          n_mismatch, n_checks, n_tx, n;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) if (tx === 1'b1) n_tx++;
  tdc_core uut (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr_s),
    .REG_WDATA_I(wdata), .REG_RD_I(rd_s), .REG_RDATA_O(rdata), .RX_PULSE_I(rx),
    .SCRAMBLER_ERR_I(scr), .TX_PULSE_O(tx), .TX_INHIBIT_O(inh), .BUSY_O(busy));
  tdc_peer peer (.clk_i(clk), .rst_i(rst), .line_in_i(tx), .echo_en_i(echo_en),
    .send_i(send), .line_out_o(rx));
  //==========================================================================
  // Register access and run helpers
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  // Counts busy cycles; a hung run ends the test rather than the simulator
  task automatic wait_idle(output int c);
    c = 0;
    @(negedge clk);
    while (busy === 1'b1 && c < 3000) begin
      @(negedge clk);
      c++;
    end
    if (c >= 3000) begin
      n_mismatch++;
      complete_run();
    end
    @(posedge clk);
  endtask
  task automatic run(input logic [15:0] ctl, input bit inj, output logic [15:0] s);
    // Let a late echo of the last run drain, or it would read as line traffic
    repeat (4) @(posedge clk);
    n_tx = 0;
    wr(TDC_ADDR_CTRL, ctl);
    rd(TDC_ADDR_STATUS, s);
    `CHK("done_mid", 1'b0, s[15])
    if (inj) begin
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
    end
    wait_idle(n);
    rd(TDC_ADDR_STATUS, s);
  endtask
  //==========================================================================
  // Scenarios
  initial begin
    rst = 1'b1; wr_s = 1'b0; rd_s = 1'b0; addr = 16'h0000; wdata = 16'h0000;
    scr = 1'b0; echo_en = 1'b0; send = 1'b0; n_mismatch = 0; n_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(TDC_ADDR_CTRL, 16'h0000);
    rd_chk(TDC_ADDR_STATUS, 16'h8000);
    rd_chk(TDC_ADDR_RESULT, 16'h0000);
    rd_chk(TDC_ADDR_DURATION, 16'h7530);
    rd_chk(16'h0030, 16'h0000);
    wr(TDC_ADDR_DURATION, 16'h0005);
    rd_chk(TDC_ADDR_DURATION, 16'h0005);
    rd_chk(TDC_ADDR_PRECISE, 16'h0FA0);
    wr(TDC_ADDR_STATUS, 16'h0000);
    rd_chk(TDC_ADDR_STATUS, 16'h8000);
    wr(TDC_ADDR_CTRL, 16'h0300);
    wait_idle(n);
    `CHK("refused", 0, n)
    `CHK("inhibit_off", 1'b0, inh)
    `CHK("refused_busy", 1'b0, busy)
    run(16'h8701, 1'b0, st);
    `CHK("man_cal", 16'h8000, st)
    `CHK("cal_len", 1'b1, n >= 490 && n < 520)
    `CHK("inhibit_on", 1'b1, inh)
    rd_chk(TDC_ADDR_RESULT, 16'h0000);
    rd_chk(TDC_ADDR_CTRL, 16'h8601);
    echo_en <= 1'b1;
    run(16'h8301, 1'b0, st);
    `CHK("man_meas", 16'h8000, st)
    `CHK("ref_pulses", 1'b1, n_tx > 0)
    rd(TDC_ADDR_RESULT, res);
    `CHK("result", 1'b1, res != 16'h0000)
    scr <= 1'b1;
    run(16'h8301, 1'b0, st);
    `CHK("scr_on", 16'h8002, st)
    run(16'h8311, 1'b0, st);
    `CHK("scr_off", 16'h8000, st)
    scr <= 1'b0;
    run(16'h8501, 1'b0, st);
    `CHK("auto", 16'h8000, st)
    `CHK("auto_len", 1'b1, n > 550)
    // A short measurement would end before the echo timeout could flag anything
    wr(TDC_ADDR_DURATION, 16'h0100);
    echo_en <= 1'b0;
    run(16'h8301, 1'b0, st);
    `CHK("no_echo", 16'h8002, st)
    wr(TDC_ADDR_DURATION, 16'h0005);
    echo_en <= 1'b1;
    run(16'h8301, 1'b0, st);
    `CHK("rerun", 16'h8000, st)
    echo_en <= 1'b0;
    run(16'h8101, 1'b0, st);
    `CHK("hand_err", 16'h8004, st & 16'h8004)
    run(16'h8101, 1'b1, st);
    `CHK("cal_err_auto", 16'h8001, st & 16'h8001)
    run(16'h8701, 1'b1, st);
    `CHK("cal_err_man", 16'h8001, st & 16'h8001)
    run(16'h8300, 1'b1, st);
    `CHK("echo_once", 1, n_tx)
    echo_en <= 1'b1;
    wr(TDC_ADDR_CTRL, 16'h8301);
    @(posedge clk);
    wr(TDC_ADDR_CTRL, 16'h0001);
    wait_idle(n);
    `CHK("abort_len", 1'b1, n < 5)
    rd_chk(TDC_ADDR_STATUS, 16'h8000);
    complete_run();
  end
endmodule
